// file: src/psd_lane_alu.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] Lane add, truncated per lane, no carry
// [RULE2] Lane subtract, truncated per lane, no borrow
// [RULE3] Signed average: truncated sum, arithmetic shift one
// [RULE4] Unsigned average: logical shift, immediate zero-extended
// [RULE5] Signed minimum picks smaller two's-complement lane
// [RULE6] Unsigned min/max compare unsigned, zero-extend immediate
// [RULE7] Signed maximum picks larger lane
// [RULE8] Shift amount: low 4 or 3 bits only
// [RULE9] Software keeps unused shift amount bits zero
// [RULE10] Logical shifts fill zero, immediate zero-extended
// [RULE11] Arithmetic right shift fills lane sign bit
// [RULE12] Lane OR, XOR, AND bit by bit
// [RULE13] Absolute value negates negative lanes only
// [RULE14] Signed pick selects lane, sign-extends to 32
// [RULE15] Unsigned pick selects lane, zero-extends to 32
// [RULE16] Place writes low lane, keeps other destination bits
// [RULE17] Dot product sums two or four lane products
// [RULE18] Accumulating dot adds prior destination value
// [RULE19] Unsigned dot treats all lanes unsigned
// [RULE20] Mixed dot: first unsigned, second operand signed
// [RULE21] Signed dot treats all lanes signed
// [RULE22] Scalar form replicates low lane; immediate replicated
// [RULE23] Immediate sign-extended unless operation says otherwise
// [RULE24] Lane 0 in low bits, ascending upward
// [RULE25] No overflow or carry flags produced
// [RULE26] Dot sums kept modulo 2^32, no saturation
// [RULE27] Operations available only with extension parameter enabled
module psd_lane_alu #(
  parameter bit customExtEnableParam = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Request from decode
  input wire logic reqValid,
  input wire psd_pkg::psd_op_t opCode,
  input wire psd_pkg::psd_lane_t laneSize,
  input wire psd_pkg::psd_form_t operandForm,
  input wire logic [31:0] firstSource,
  input wire logic [31:0] secondSource,
  input wire logic [5:0] sixBitImmediate,
  input wire logic [31:0] destPrior,
  // Result to write-back
  output logic resValid_r,
  output logic [31:0] resData_r,
  output logic unavailable_r
);

  // One lane held in a 16-bit slot; byte lanes live in the low 8 bits
  function automatic logic [15:0] laneCalc(input psd_pkg::psd_op_t op,
                                           input logic isByte,
                                           input logic [15:0] a,
                                           input logic [15:0] b);
    logic [15:0] mask;
    logic [15:0] topBit;
    logic [15:0] sa;
    logic [15:0] sb;
    logic [15:0] ua;
    logic [15:0] ub;
    logic [15:0] sum;
    logic [3:0] sh;
    logic [15:0] res;
    mask = isByte ? psd_pkg::BYTE_MASK : psd_pkg::HALF_MASK;
    topBit = isByte ? psd_pkg::BYTE_TOP_BIT : psd_pkg::HALF_TOP_BIT;
    ua = a & mask;
    ub = b & mask;
    sa = isByte ? {{8{a[7]}}, a[7:0]} : a;
    sb = isByte ? {{8{b[7]}}, b[7:0]} : b;
    sum = (ua + ub) & mask; // RULE1
    sh = isByte ? {1'b0, b[2:0]} : b[3:0]; // RULE8
    case (op)
      psd_pkg::OP_LANE_ADD: res = sum; // RULE1
      psd_pkg::OP_LANE_SUBTRACT: res = ua - ub; // RULE2
      psd_pkg::OP_LANE_AVERAGE_SIGNED: res = (sum >> 1) | ((sum & topBit) != 16'h0000 ? topBit : 16'h0000); // RULE3
      psd_pkg::OP_LANE_AVERAGE_UNSIGNED: res = sum >> 1; // RULE4
      psd_pkg::OP_LANE_MINIMUM_SIGNED: res = ($signed(sa) < $signed(sb)) ? ua : ub; // RULE5
      psd_pkg::OP_LANE_MINIMUM_UNSIGNED: res = (ua < ub) ? ua : ub; // RULE6
      psd_pkg::OP_LANE_MAXIMUM_SIGNED: res = ($signed(sa) > $signed(sb)) ? ua : ub; // RULE7
      psd_pkg::OP_LANE_MAXIMUM_UNSIGNED: res = (ua > ub) ? ua : ub; // RULE6
      psd_pkg::OP_LANE_SHIFT_RIGHT_LOGICAL: res = ua >> sh; // RULE10
      psd_pkg::OP_LANE_SHIFT_RIGHT_ARITH: res = 16'($signed(sa) >>> sh); // RULE11
      psd_pkg::OP_LANE_SHIFT_LEFT: res = ua << sh; // RULE10
      psd_pkg::OP_LANE_BITWISE_OR: res = ua | ub; // RULE12
      psd_pkg::OP_LANE_BITWISE_XOR: res = ua ^ ub; // RULE12
      psd_pkg::OP_LANE_BITWISE_AND: res = ua & ub; // RULE12
      psd_pkg::OP_LANE_ABSOLUTE_VALUE: res = sa[15] ? 16'(-sa) : sa; // RULE13
      default: res = 16'h0000;
    endcase
    return res & mask; // RULE1 RULE2
  endfunction

  // Immediate extension: zero for unsigned average, min, max and shift forms, otherwise sign
  function automatic logic immZeroExt(input psd_pkg::psd_op_t op);
    case (op)
      psd_pkg::OP_LANE_AVERAGE_UNSIGNED,
      psd_pkg::OP_LANE_MINIMUM_UNSIGNED,
      psd_pkg::OP_LANE_MAXIMUM_UNSIGNED,
      psd_pkg::OP_LANE_SHIFT_RIGHT_LOGICAL,
      psd_pkg::OP_LANE_SHIFT_RIGHT_ARITH,
      psd_pkg::OP_LANE_SHIFT_LEFT: return 1'b1; // RULE4 RULE6 RULE10 RULE11
      default: return 1'b0; // RULE23
    endcase
  endfunction

  // Operand decode
  wire logic isByte = (laneSize == psd_pkg::LANE_BYTE);
  wire logic zeroExt = immZeroExt(opCode);
  wire logic [15:0] immHalf = zeroExt ? {10'h000, sixBitImmediate} :
                                        {{10{sixBitImmediate[5]}}, sixBitImmediate};
  wire logic [7:0] immByte = zeroExt ? {2'b00, sixBitImmediate} :
                                       {{2{sixBitImmediate[5]}}, sixBitImmediate};

  // Second operand per form; scalar forms replicate the lowest lane
  wire logic [31:0] scalarRep = isByte ? {4{secondSource[7:0]}} :
                                         {2{secondSource[15:0]}}; // RULE22
  wire logic [31:0] immRep = isByte ? {4{immByte}} : {2{immHalf}}; // RULE22 RULE23
  wire logic [31:0] secondOperand =
    (operandForm == psd_pkg::FORM_SCALAR_REPLICATE) ? scalarRep :
    (operandForm == psd_pkg::FORM_IMMEDIATE) ? immRep : secondSource;

  // Halfword lanes: lane 0 is bits 15:0
  wire logic [31:0] halfRes = {laneCalc(opCode, 1'b0, firstSource[31:16], secondOperand[31:16]),
                               laneCalc(opCode, 1'b0, firstSource[15:0], secondOperand[15:0])}; // RULE24

  // Byte lanes: lane i is bits 8i+7:8i, each computed apart so nothing crosses
  wire logic [15:0] byteWide [psd_pkg::BYTE_LANES];
  wire logic [31:0] byteRes;
  for (genvar i = 0; i < psd_pkg::BYTE_LANES; i++) begin : gByte
    assign byteWide[i] = laneCalc(opCode, 1'b1, {8'h00, firstSource[8*i +: 8]},
                                  {8'h00, secondOperand[8*i +: 8]});
    assign byteRes[8*i +: 8] = byteWide[i][7:0]; // RULE24
  end

  // Lane pick and place, lane chosen by the low immediate bits
  wire logic [1:0] byteSel = sixBitImmediate[1:0];
  wire logic halfSel = sixBitImmediate[0];
  wire logic [15:0] pickHalf = firstSource[16*halfSel +: 16];
  wire logic [7:0] pickByte = firstSource[8*byteSel +: 8];
  wire logic pickSign = (opCode == psd_pkg::OP_LANE_PICK_SIGNED) &
                        (isByte ? pickByte[7] : pickHalf[15]); // RULE14 RULE15
  wire logic [31:0] pickRes = isByte ? {{24{pickSign}}, pickByte} :
                                       {{16{pickSign}}, pickHalf};
  logic [31:0] placeRes;

  // Place overwrites one lane only; the rest keep the prior destination
  always_comb begin
    placeRes = destPrior;
    if (isByte) begin
      placeRes[8*byteSel +: 8] = firstSource[7:0]; // RULE16
    end else begin
      placeRes[16*halfSel +: 16] = firstSource[15:0]; // RULE16
    end
  end

  // Dot product unit hookup
  psd_dot_if dotBus ();
  wire logic dotOp = (opCode >= psd_pkg::OP_DOT_UU);
  assign dotBus.a = firstSource;
  assign dotBus.b = secondOperand;
  assign dotBus.prior = destPrior;
  assign dotBus.isByte = isByte;
  assign dotBus.aSigned = (opCode == psd_pkg::OP_DOT_SS) |
                          (opCode == psd_pkg::OP_DOT_SS_ACCUMULATE); // RULE19 RULE20 RULE21
  assign dotBus.bSigned = dotBus.aSigned | (opCode == psd_pkg::OP_DOT_US) |
                          (opCode == psd_pkg::OP_DOT_US_ACCUMULATE); // RULE20 RULE21
  assign dotBus.accumulate = (opCode >= psd_pkg::OP_DOT_UU_ACCUMULATE); // RULE18

  psd_dot_unit uDot (
    .dot(dotBus)
  );

  // Final result selection; the only flag output is unavailable_r, so nothing reports overflow
  wire logic isPick = (opCode == psd_pkg::OP_LANE_PICK_SIGNED) |
                      (opCode == psd_pkg::OP_LANE_PICK_UNSIGNED);
  wire logic [31:0] result =
    dotOp ? dotBus.sum :
    isPick ? pickRes :
    (opCode == psd_pkg::OP_LANE_PLACE) ? placeRes :
    isByte ? byteRes : halfRes; // RULE25

  // Result register: one cycle from request to write-back
  always_ff @(posedge clock) begin
    if (!rstn) begin
      resValid_r <= 1'b0;
      resData_r <= psd_pkg::RESULT_RESET;
      unavailable_r <= 1'b0;
    end else begin
      resValid_r <= reqValid;
      resData_r <= (reqValid && customExtEnableParam) ? result : psd_pkg::RESULT_RESET; // RULE27
      unavailable_r <= reqValid & ~customExtEnableParam; // RULE27
    end
  end

  // Checking aids: operands of the request one cycle back
  logic [31:0] hA_r;
  logic [31:0] hB_r;
  logic [31:0] hD_r;

  always_ff @(posedge clock) begin
    hA_r <= firstSource;
    hB_r <= secondOperand;
    hD_r <= destPrior;
  end

  default clocking cbMain @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Request shapes
  sequence sReq(psd_pkg::psd_op_t op, psd_pkg::psd_lane_t ls);
    reqValid && customExtEnableParam && opCode == op && laneSize == ls;
  endsequence

  sequence sHalfAdd;
    sReq(psd_pkg::OP_LANE_ADD, psd_pkg::LANE_HALF);
  endsequence

  chk_add_lane_wrap: assert property (sHalfAdd |=> // RULE1
    resData_r[15:0] == 16'(hA_r[15:0] + hB_r[15:0]) &&
    resData_r[31:16] == 16'(hA_r[31:16] + hB_r[31:16]))
    else $error("half add lane result wrong");

  chk_sub_byte_lanes: assert property ( // RULE2
    sReq(psd_pkg::OP_LANE_SUBTRACT, psd_pkg::LANE_BYTE) |=>
    resData_r[7:0] == 8'(hA_r[7:0] - hB_r[7:0]) &&
    resData_r[31:24] == 8'(hA_r[31:24] - hB_r[31:24]))
    else $error("byte subtract lane result wrong");

  chk_avg_sign_fill: assert property ( // RULE3
    sReq(psd_pkg::OP_LANE_AVERAGE_SIGNED, psd_pkg::LANE_HALF) |=>
    resData_r[15] == resData_r[14] && resData_r[31] == resData_r[30] &&
    resData_r[13:0] == 14'(({1'b0, hA_r[15:0]} + {1'b0, hB_r[15:0]}) >> 1))
    else $error("signed average not sign filled");

  chk_avgu_top_zero: assert property ( // RULE4
    sReq(psd_pkg::OP_LANE_AVERAGE_UNSIGNED, psd_pkg::LANE_BYTE) |=>
    !resData_r[7] && !resData_r[15] && !resData_r[23] && !resData_r[31])
    else $error("unsigned average top bit set");

  chk_min_signed_pick: assert property ( // RULE5
    sReq(psd_pkg::OP_LANE_MINIMUM_SIGNED, psd_pkg::LANE_HALF) |=>
    resData_r[15:0] == (($signed(hA_r[15:0]) < $signed(hB_r[15:0])) ? hA_r[15:0] : hB_r[15:0]))
    else $error("signed minimum picked wrong lane");

  chk_shift_amount_mask: assert property ( // RULE8
    sReq(psd_pkg::OP_LANE_SHIFT_LEFT, psd_pkg::LANE_BYTE) |=>
    resData_r[7:0] == 8'(hA_r[7:0] << hB_r[2:0]))
    else $error("byte shift used wrong amount bits");

  chk_place_keeps_rest: assert property ( // RULE16
    sReq(psd_pkg::OP_LANE_PLACE, psd_pkg::LANE_HALF) ##0 !sixBitImmediate[0] |=>
    resData_r == {hD_r[31:16], hA_r[15:0]})
    else $error("place disturbed other lane");

  chk_dot_acc_sum: assert property ( // RULE18
    sReq(psd_pkg::OP_DOT_UU_ACCUMULATE, psd_pkg::LANE_HALF) |=>
    resData_r == hD_r + {16'h0000, hA_r[15:0]} * {16'h0000, hB_r[15:0]} +
                 {16'h0000, hA_r[31:16]} * {16'h0000, hB_r[31:16]})
    else $error("accumulating dot product wrong");

  chk_unavailable_flag: assert property ( // RULE27
    reqValid |=> resValid_r && unavailable_r == !customExtEnableParam ##1
    (resValid_r == $past(reqValid)))
    else $error("valid or unavailable flag wrong");

endmodule

// file: shared/psd_pkg.sv
// Shared definitions for the packed lane datapath
package psd_pkg;

  // Lane geometry
  localparam int HALF_WIDTH = 16;
  localparam int BYTE_WIDTH = 8;
  localparam int HALF_LANES = 2;
  localparam int BYTE_LANES = 4;

  // Lane masks applied to every lane result
  localparam logic [15:0] HALF_MASK = 16'hffff;
  localparam logic [15:0] BYTE_MASK = 16'h00ff;

  // Sign bit position of a lane held in a 16-bit slot
  localparam logic [15:0] HALF_TOP_BIT = 16'h8000;
  localparam logic [15:0] BYTE_TOP_BIT = 16'h0080;

  // Shift amount fields: low bits of the lane that are honoured
  localparam int HALF_SHIFT_BITS = 4;
  localparam int BYTE_SHIFT_BITS = 3;

  // Immediate width and reset value of the result register
  localparam int IMM_WIDTH = 6;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // Operations handled by the datapath
  typedef enum logic [4:0] {
    OP_LANE_ADD,
    OP_LANE_SUBTRACT,
    OP_LANE_AVERAGE_SIGNED,
    OP_LANE_AVERAGE_UNSIGNED,
    OP_LANE_MINIMUM_SIGNED,
    OP_LANE_MINIMUM_UNSIGNED,
    OP_LANE_MAXIMUM_SIGNED,
    OP_LANE_MAXIMUM_UNSIGNED,
    OP_LANE_SHIFT_RIGHT_LOGICAL,
    OP_LANE_SHIFT_RIGHT_ARITH,
    OP_LANE_SHIFT_LEFT,
    OP_LANE_BITWISE_OR,
    OP_LANE_BITWISE_XOR,
    OP_LANE_BITWISE_AND,
    OP_LANE_ABSOLUTE_VALUE,
    OP_LANE_PICK_SIGNED,
    OP_LANE_PICK_UNSIGNED,
    OP_LANE_PLACE,
    OP_DOT_UU,
    OP_DOT_US,
    OP_DOT_SS,
    OP_DOT_UU_ACCUMULATE,
    OP_DOT_US_ACCUMULATE,
    OP_DOT_SS_ACCUMULATE
  } psd_op_t;

  // Lane size
  typedef enum logic {
    LANE_HALF,
    LANE_BYTE
  } psd_lane_t;

  // Source of the second operand
  typedef enum logic [1:0] {
    FORM_VECTOR,
    FORM_SCALAR_REPLICATE,
    FORM_IMMEDIATE
  } psd_form_t;

endpackage

// file: shared/psd_dot_if.sv
`timescale 1ns/1ps
// Operands and sum between the lane datapath and the dot product unit
interface psd_dot_if;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] prior;
  logic isByte;
  logic aSigned;
  logic bSigned;
  logic accumulate;
  logic [31:0] sum;

  modport requester (output a, output b, output prior, output isByte, output aSigned,
                     output bSigned, output accumulate, input sum);
  modport unit (input a, input b, input prior, input isByte, input aSigned,
                input bSigned, input accumulate, output sum);
endinterface

// file: src/psd_dot_unit.sv
`timescale 1ns/1ps
// Sum of lane products, optionally added to the prior destination value
module psd_dot_unit (
  // Operand and sum carrier
  psd_dot_if.unit dot
);

  // Extend one lane to 17 bits by its signedness and multiply; 34 bits never overflow
  function automatic logic signed [33:0] mulLane(input logic [15:0] a,
                                                 input logic [15:0] b,
                                                 input logic isByte,
                                                 input logic aS,
                                                 input logic bS);
    logic signed [16:0] ea;
    logic signed [16:0] eb;
    ea = isByte ? {{9{aS & a[7]}}, a[7:0]} : {aS & a[15], a[15:0]};
    eb = isByte ? {{9{bS & b[7]}}, b[7:0]} : {bS & b[15], b[15:0]};
    return 34'(ea) * 34'(eb);
  endfunction

  logic [31:0] rawSum;

  // Products summed modulo 2^32, no saturation
  always_comb begin
    logic signed [33:0] prod;
    prod = '0;
    rawSum = 32'h0000_0000;
    for (int i = 0; i < psd_pkg::BYTE_LANES; i++) begin
      if (dot.isByte) begin
        prod = mulLane({8'h00, dot.a[8*i +: 8]}, {8'h00, dot.b[8*i +: 8]}, 1'b1,
                       dot.aSigned, dot.bSigned); // RULE17
      end else if (i < psd_pkg::HALF_LANES) begin
        prod = mulLane(dot.a[16*i +: 16], dot.b[16*i +: 16], 1'b0,
                       dot.aSigned, dot.bSigned); // RULE17
      end else begin
        prod = '0;
      end
      rawSum = rawSum + prod[31:0]; // RULE26
    end
  end

  // Accumulating forms fold in the old destination
  assign dot.sum = dot.accumulate ? rawSum + dot.prior : rawSum; // RULE18 RULE26

endmodule

// file: verification/psd_rf_model.sv
`timescale 1ns/1ps
// Destination register of the write-back stage, with a forwarding path
module psd_rf_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Write-back from the datapath
  input wire logic resValid_r,
  input wire logic [31:0] resData_r,
  // Old destination value offered with the next request
  output logic [31:0] destPrior
);
  logic [31:0] destReg_r;

  // Keeps the last written result; cleared on reset so the bench shadow can start at zero
  always_ff @(posedge clock) begin
    if (!rstn) begin
      destReg_r <= 32'h0000_0000;
    end else if (resValid_r) begin
      destReg_r <= resData_r;
    end
  end

  // Forward the standing result, else back-to-back accumulates would read a stale value
  assign destPrior = resValid_r ? resData_r : destReg_r;
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0;
  psd_pkg::psd_op_t opCode = psd_pkg::OP_LANE_ADD;
  psd_pkg::psd_lane_t laneSize = psd_pkg::LANE_HALF;
  psd_pkg::psd_form_t operandForm = psd_pkg::FORM_VECTOR;
  logic [31:0] firstSource = 32'h0000_0000;
  logic [31:0] secondSource = 32'h0000_0000;
  logic [5:0] sixBitImmediate = 6'h00;
  logic [31:0] destPrior;
  logic resValid_r, unavailable_r, offValid, offUnavail, reqSeen = 1'b0, armed = 1'b0;
  logic [31:0] resData_r, offData, monExp, shadow = 32'h0000_0000, da, ds;
  logic [5:0] dim;
  logic [31:0] expQ[$];
  logic [31:0] edgeVals[4] = '{32'h8000_0080, 32'h7fff_ff7f, 32'h0000_0000, 32'hffff_ffff};
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 32'ha910;

  psd_lane_alu u_dut (.clock(clock), .rstn(rstn), .reqValid(reqValid), .opCode(opCode),
    .laneSize(laneSize), .operandForm(operandForm), .firstSource(firstSource),
    .secondSource(secondSource), .sixBitImmediate(sixBitImmediate), .destPrior(destPrior),
    .resValid_r(resValid_r), .resData_r(resData_r), .unavailable_r(unavailable_r));
  // Same stimulus into a copy built without the extension
  psd_lane_alu #(.customExtEnableParam(1'b0)) u_dut_off (.clock(clock), .rstn(rstn),
    .reqValid(reqValid), .opCode(opCode), .laneSize(laneSize), .operandForm(operandForm),
    .firstSource(firstSource), .secondSource(secondSource), .sixBitImmediate(sixBitImmediate),
    .destPrior(destPrior), .resValid_r(offValid), .resData_r(offData),
    .unavailable_r(offUnavail));
  psd_rf_model u_rf (.clock(clock), .rstn(rstn), .resValid_r(resValid_r),
    .resData_r(resData_r), .destPrior(destPrior));

  always #10 clock = ~clock;

  // Sign view of a lane value of width w
  function automatic longint sx(longint v, int w);
    return v[w-1] ? v - (longint'(1) << w) : v;
  endfunction

  // Expected destination value for one request
  function automatic logic [31:0] ref_op(psd_pkg::psd_op_t op, bit isB, psd_pkg::psd_form_t fm,
      logic [31:0] a, logic [31:0] s, logic [5:0] im, logic [31:0] pr);
    int w, n, k;
    longint m, x, y, t, e, acc;
    logic [31:0] r;
    w = isB ? 8 : 16;
    n = 32 / w;
    m = (longint'(1) << w) - 1;
    k = isB ? int'(im[1:0]) : int'(im[0]);
    e = op inside {psd_pkg::OP_LANE_AVERAGE_UNSIGNED, psd_pkg::OP_LANE_MINIMUM_UNSIGNED,
      psd_pkg::OP_LANE_MAXIMUM_UNSIGNED, psd_pkg::OP_LANE_SHIFT_RIGHT_LOGICAL,
      psd_pkg::OP_LANE_SHIFT_RIGHT_ARITH, psd_pkg::OP_LANE_SHIFT_LEFT} ?
      longint'(im) : sx(longint'(im), 6);
    acc = op inside {psd_pkg::OP_DOT_UU_ACCUMULATE, psd_pkg::OP_DOT_US_ACCUMULATE,
      psd_pkg::OP_DOT_SS_ACCUMULATE} ? longint'(pr) : 0;
    r = 32'h0000_0000;
    for (int i = 0; i < n; i++) begin
      x = (a >> (i * w)) & m;
      y = fm == psd_pkg::FORM_IMMEDIATE ? e & m :
        fm == psd_pkg::FORM_SCALAR_REPLICATE ? s & m : (s >> (i * w)) & m;
      t = (x + y) & m;
      case (op)
        psd_pkg::OP_LANE_SUBTRACT: t = x - y;
        psd_pkg::OP_LANE_AVERAGE_SIGNED: t = (t >> 1) | (t & (m ^ (m >> 1)));
        psd_pkg::OP_LANE_AVERAGE_UNSIGNED: t = t >> 1;
        psd_pkg::OP_LANE_MINIMUM_SIGNED: t = sx(x, w) < sx(y, w) ? x : y;
        psd_pkg::OP_LANE_MINIMUM_UNSIGNED: t = x < y ? x : y;
        psd_pkg::OP_LANE_MAXIMUM_SIGNED: t = sx(x, w) > sx(y, w) ? x : y;
        psd_pkg::OP_LANE_MAXIMUM_UNSIGNED: t = x > y ? x : y;
        psd_pkg::OP_LANE_SHIFT_RIGHT_LOGICAL: t = x >> (y & (w - 1));
        psd_pkg::OP_LANE_SHIFT_RIGHT_ARITH: t = sx(x, w) >>> (y & (w - 1));
        psd_pkg::OP_LANE_SHIFT_LEFT: t = x << (y & (w - 1));
        psd_pkg::OP_LANE_BITWISE_OR: t = x | y;
        psd_pkg::OP_LANE_BITWISE_XOR: t = x ^ y;
        psd_pkg::OP_LANE_BITWISE_AND: t = x & y;
        psd_pkg::OP_LANE_ABSOLUTE_VALUE: t = sx(x, w) < 0 ? -x : x;
        psd_pkg::OP_DOT_UU, psd_pkg::OP_DOT_UU_ACCUMULATE: acc += x * y;
        psd_pkg::OP_DOT_US, psd_pkg::OP_DOT_US_ACCUMULATE: acc += x * sx(y, w);
        psd_pkg::OP_DOT_SS, psd_pkg::OP_DOT_SS_ACCUMULATE: acc += sx(x, w) * sx(y, w);
        default: t = t;
      endcase
      r = r | 32'((t & m) << (i * w));
    end
    t = (a >> (k * w)) & m;
    if (op >= psd_pkg::OP_DOT_UU) r = 32'(acc);
    if (op == psd_pkg::OP_LANE_PICK_SIGNED) r = 32'(sx(t, w));
    if (op == psd_pkg::OP_LANE_PICK_UNSIGNED) r = 32'(t);
    if (op == psd_pkg::OP_LANE_PLACE) r = (pr & ~32'(m << (k * w))) | 32'((a & m) << (k * w));
    return r;
  endfunction

  task automatic fail(string msg);
    mismatches++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One request per call; the expectation uses the bench's own copy of the destination
  task automatic issue(psd_pkg::psd_op_t op, psd_pkg::psd_lane_t ln, psd_pkg::psd_form_t fm,
      logic [31:0] a, logic [31:0] s, logic [5:0] im);
    logic [31:0] e;
    e = ref_op(op, ln == psd_pkg::LANE_BYTE, fm, a, s, im, shadow);
    reqValid = 1'b1;
    opCode = op;
    laneSize = ln;
    operandForm = fm;
    firstSource = a;
    secondSource = s;
    sixBitImmediate = im;
    expQ.push_back(e);
    shadow = e;
    @(negedge clock);
  endtask

  task automatic idle(int n);
    reqValid = 1'b0;
    repeat (n) @(negedge clock);
  endtask

  // Requests taken at each edge outside reset, for the answer one cycle later
  always @(posedge clock) begin
    reqSeen <= reqValid && rstn;
    armed <= 1'b1;
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      tally_and_finish();
    end
  end

  // Result watcher: outputs are registered, so they are settled at the falling edge
  always @(negedge clock) begin
    if (armed) begin
      monExp = reqSeen ? expQ.pop_front() : 32'h0000_0000;
      check_count++;
      if (resValid_r !== reqSeen || resData_r !== monExp || unavailable_r !== 1'b0) begin
        fail("result mismatch");
      end
      if (offValid !== reqSeen || offUnavail !== reqSeen || offData !== 32'h0000_0000) begin
        fail("disabled copy mismatch");
      end
    end
  end

  initial begin
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    issue(psd_pkg::OP_LANE_ADD, psd_pkg::LANE_HALF, psd_pkg::FORM_VECTOR, 32'h0001_ffff,
      32'h0001_0001, 6'h00);
    // Every operation, lane size and form, back to back, boundary values then random ones
    for (int k = 0; k < 24; k++) begin
      for (int l = 0; l < 2; l++) begin
        for (int f = 0; f < 3; f++) begin
          for (int j = 0; j < 6; j++) begin
            da = j < 4 ? edgeVals[j] : $random(seed);
            ds = j < 4 ? edgeVals[3 - j] : $random(seed);
            dim = 6'($random(seed));
            // Shift amounts keep their unused upper bits clear in every form
            if (k >= 8 && k <= 10) begin
              dim = dim & (l ? 6'h07 : 6'h0f);
              ds = ds & (l ? 32'h0707_0707 : 32'h000f_000f);
            end
            issue(psd_pkg::psd_op_t'(k), psd_pkg::psd_lane_t'(l), psd_pkg::psd_form_t'(f),
              da, ds, dim);
          end
        end
      end
    end
    // Reset in mid-run clears outputs and the destination
    idle(2);
    rstn = 1'b0;
    shadow = 32'h0000_0000;
    idle(2);
    rstn = 1'b1;
    idle(1);
    // Accumulation that wraps past 32 bits, back to back
    issue(psd_pkg::OP_DOT_UU_ACCUMULATE, psd_pkg::LANE_HALF, psd_pkg::FORM_VECTOR,
      32'hffff_ffff, 32'hffff_ffff, 6'h00);
    issue(psd_pkg::OP_DOT_UU_ACCUMULATE, psd_pkg::LANE_HALF, psd_pkg::FORM_VECTOR,
      32'hffff_ffff, 32'hffff_ffff, 6'h00);
    idle(3);
    tally_and_finish();
  end
endmodule
